// ===== rtl/eeid_defs.vh
// constants for the expanded external interrupt detector
`ifndef EEID_DEFS_VH
`define EEID_DEFS_VH
`define EEID_NCH 4
`define EEID_ADDR_W 16
`define EEID_DATA_W 16
`define EEID_OFF_EDGE 16'hF0E4
`define EEID_OFF_SAMP 16'hF0E8
`define EEID_OFF_DIV 16'hF0EA
`define EEID_OFF_PEND 16'hF0EC
`define EEID_OFF_CLR 16'hF0EE
`define EEID_OFF_STBY 16'hF0F0
`define EEID_EDGE_HI_MSB 11
`define EEID_EDGE_HI_LSB 8
`define EEID_EDGE_LO_MSB 3
`define EEID_EDGE_LO_LSB 0
`define EEID_DIV_MSB 6
`define EEID_DIV_LSB 4
`define EEID_DIV_MASK 16'h0070
`define EEID_EDGE_MASK 16'h0F0F
`define EEID_NIB_MASK 16'h000F
`define EEID_RERQ_BIT 15
`define EEID_RST16 16'h0000
`define EEID_EDGE_OFF 2'h0
`define EEID_EDGE_FALL 2'h1
`define EEID_EDGE_RISE 2'h2
`define EEID_EDGE_BOTH 2'h3
`define EEID_DIV_NONE_ALT 3'h7
`define EEID_STABLE_CNT 2'h3
`define EEID_PRESCALE_W 16
`define EEID_PRESCALE_DEF 16'h00F9
`define EEID_STOP_LOSS_NS 30000
`define EEID_CLK_NS 4
`endif

// ===== rtl/eeid_sync.v
// two-flop synchroniser for the interrupt pins
`timescale 1ns/1ns
module eeid_sync (
  input  wire clk,
  input  wire rst,
  input  wire din,
  output reg  dout
);
  reg meta_reg;
  always @(posedge clk) begin
    if (rst) begin
      meta_reg <= 1'b0;
      dout     <= 1'b0;
    end else begin
      meta_reg <= din;
      dout     <= meta_reg;
    end
  end
endmodule

// ===== rtl/eeid_chan.v
// one channel: edge detection, sampling filter, request and pending flag
`timescale 1ns/1ns
`include "eeid_defs.vh"
module eeid_chan (
  input  wire       clk,
  input  wire       rst,
  input  wire       pin_s,
  input  wire [1:0] edge_sel,
  input  wire       use_samp,
  input  wire       samp_en,
  input  wire       samp_run,
  input  wire       clr,
  input  wire       rerq,
  output reg        req,
  output reg        pend,
  output reg        trig
);
  reg       prev_reg;
  reg       samp_reg;
  reg       cand_reg;
  reg       armed_reg;
  reg [1:0] stab_reg;
  reg       hit;
  wire      rise_d = pin_s & ~prev_reg;
  wire      fall_d = ~pin_s & prev_reg;
  wire      rise_s = pin_s & ~samp_reg;
  wire      fall_s = ~pin_s & samp_reg;

  // (RULE1) edge decode helper
  function sel_edge;
    input [1:0] sel;
    input       r;
    input       f;
    begin
      case (sel)
        `EEID_EDGE_FALL: sel_edge = f;
        `EEID_EDGE_RISE: sel_edge = r;
        `EEID_EDGE_BOTH: sel_edge = r | f;
        default:         sel_edge = 1'b0;
      endcase
    end
  endfunction

  always @* begin
    hit = 1'b0;
    if (!use_samp) begin
      // (RULE16) direct system clock
      hit = sel_edge(edge_sel, rise_d, fall_d);
    end else if (samp_en && samp_run && armed_reg && pin_s == cand_reg) begin
      // (RULE17) stable three sample periods
      if (stab_reg == `EEID_STABLE_CNT - 2'h1) begin
        hit = 1'b1;
      end
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      prev_reg  <= 1'b0;
      samp_reg  <= 1'b0;
      cand_reg  <= 1'b0;
      armed_reg <= 1'b0;
      stab_reg  <= 2'h0;
      req       <= 1'b0;
      pend      <= 1'b0;
      trig      <= 1'b0;
    end else begin
      prev_reg <= pin_s;
      // (RULE18) trigger follows filtered or direct level
      trig <= use_samp ? samp_reg : pin_s;
      // (RULE5) sampling halts in stop standby
      if (!samp_run) begin
        armed_reg <= 1'b0;
        stab_reg  <= 2'h0;
        samp_reg  <= pin_s;
      end else if (use_samp && samp_en) begin
        samp_reg <= pin_s;
        if (sel_edge(edge_sel, rise_s, fall_s)) begin
          armed_reg <= 1'b1;
          cand_reg  <= pin_s;
          stab_reg  <= 2'h0;
        end else if (armed_reg) begin
          if (pin_s != cand_reg) begin
            armed_reg <= 1'b0;
          end else if (hit) begin
            armed_reg <= 1'b0;
          end else begin
            stab_reg <= stab_reg + 2'h1;
          end
        end
      end
      // (RULE11) no new request while pending
      // (RULE12) re-request while pending
      req <= (hit & ~pend) | (rerq & pend);
      // (RULE19) edge beats clear
      if (hit) begin
        pend <= 1'b1;
      end else if (clr) begin
        // (RULE10) write-one clear
        pend <= 1'b0;
      end
    end
  end
endmodule

// ===== rtl/eeid_top.v
// expanded external interrupt detector, four channels, avalon-mm slave
// How it works
// (RULE1) select 00 off, 01 falling, 10 rising, 11 both; reset off
// (RULE2) edge control: high selects bits 11..8, low selects 3..0
// (RULE3) sampling register bits 3..0 pick filtered or direct detection
// (RULE4) software should set every sampling bit to one
// (RULE5) stop standby halts sampling; sampled detection stops
// (RULE6) divider bits 6..4: none, 1/2 up to 1/64
// (RULE7) divider 111 must not be used; acts as no division
// (RULE8) software writes zero to divider register bit 2
// (RULE9) read-only pending flags in bits 3..0, reset zero
// (RULE10) writing one to clear bit n clears flag n
// (RULE11) pending flag blocks further requests on that channel
// (RULE12) writing bit 15 re-requests while any flag pends
// (RULE13) software re-requests before handler return and after request writes
// (RULE14) clear register always reads zero
// (RULE15) software never sets re-request with clear bits together
// (RULE16) direct detection requests synchronous to system clock
// (RULE17) sampled detection requests after three stable sample periods
// (RULE18) pins also drive timer trigger inputs, optionally filtered
// (RULE19) qualified edge gives one-cycle request, sets flag; edge beats clear
// (RULE20) pins pass two flip-flops before edge detection
//
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/1ns
`include "eeid_defs.vh"
module eeid_top (
  input  wire                     REF_CLK,
  input  wire                     RESET,
  input  wire [`EEID_ADDR_W-1:0]  AVS_ADDRESS,
  input  wire                     AVS_READ,
  input  wire                     AVS_WRITE,
  input  wire [`EEID_DATA_W-1:0]  AVS_WRITEDATA,
  output reg  [`EEID_DATA_W-1:0]  AVS_READDATA,
  output reg                      AVS_WAITREQUEST,
  input  wire [`EEID_NCH-1:0]     XIRQ_PIN,
  input  wire                     STOP_MODE,
  output reg  [`EEID_NCH-1:0]     XIRQ_REQUEST,
  output reg  [`EEID_NCH-1:0]     TIMER_TRIGGER_IN
);
  reg  [`EEID_DATA_W-1:0]     edge_select_ctrl_reg;
  reg  [`EEID_NCH-1:0]        sampling_enable_ctrl_reg;
  reg  [2:0]                  sample_div_sel_reg;
  reg  [`EEID_PRESCALE_W-1:0] prescale_reg;
  reg  [`EEID_PRESCALE_W-1:0] pre_cnt_reg;
  reg  [5:0]                  div_cnt_reg;
  reg                         samp_en_reg;
  reg  [5:0]                  div_mask;
  reg                         stop_s1_reg;
  reg                         stop_s2_reg;
  reg                         bus_done_reg;
  reg                         clr_wr_reg;
  reg  [`EEID_NCH-1:0]        clr_bits_reg;
  reg                         rerq_reg;
  reg  [`EEID_DATA_W-1:0]     rd_next;
  wire [`EEID_NCH-1:0]        pin_s;
  wire [`EEID_NCH-1:0]        req_w;
  wire [`EEID_NCH-1:0]        pend_w;
  wire [`EEID_NCH-1:0]        trig_w;
  // a prescale shrunk below the count must not wait for a 16-bit wrap
  wire                        pre_tick = (pre_cnt_reg >= prescale_reg);
  wire                        bus_req = (AVS_READ | AVS_WRITE) & ~bus_done_reg;
  wire                        samp_run = ~stop_s2_reg;

  // (RULE6) divide ratio mask
  // (RULE7) 111 behaves as no division
  always @* begin
    case (sample_div_sel_reg)
      3'h1:    div_mask = 6'h01;
      3'h2:    div_mask = 6'h03;
      3'h3:    div_mask = 6'h07;
      3'h4:    div_mask = 6'h0F;
      3'h5:    div_mask = 6'h1F;
      3'h6:    div_mask = 6'h3F;
      default: div_mask = 6'h00;
    endcase
  end

  // sampling clock source is a prescaled enable, then divided
  always @(posedge REF_CLK) begin
    if (RESET) begin
      pre_cnt_reg <= {`EEID_PRESCALE_W{1'b0}};
      div_cnt_reg <= 6'h00;
      samp_en_reg <= 1'b0;
    end else begin
      samp_en_reg <= 1'b0;
      pre_cnt_reg <= pre_tick ? {`EEID_PRESCALE_W{1'b0}} : pre_cnt_reg + 16'h0001;
      if (pre_tick) begin
        div_cnt_reg <= (div_cnt_reg + 6'h01) & div_mask;
        samp_en_reg <= ((div_cnt_reg & div_mask) == div_mask);
      end
    end
  end

  // stop request comes from another block, synchronised as a level
  always @(posedge REF_CLK) begin
    if (RESET) begin
      stop_s1_reg <= 1'b0;
      stop_s2_reg <= 1'b0;
    end else begin
      stop_s1_reg <= STOP_MODE;
      stop_s2_reg <= stop_s1_reg;
    end
  end

  genvar g;
  generate
    for (g = 0; g < `EEID_NCH; g = g + 1) begin : ch
      // (RULE20) pin synchroniser
      eeid_sync u_sync (
        .clk  (REF_CLK),
        .rst  (RESET),
        .din  (XIRQ_PIN[g]),
        .dout (pin_s[g])
      );
      eeid_chan u_chan (
        .clk      (REF_CLK),
        .rst      (RESET),
        .pin_s    (pin_s[g]),
        .edge_sel ({edge_select_ctrl_reg[`EEID_EDGE_HI_LSB+g],
                    edge_select_ctrl_reg[`EEID_EDGE_LO_LSB+g]}),
        .use_samp (sampling_enable_ctrl_reg[g]),
        .samp_en  (samp_en_reg),
        .samp_run (samp_run),
        .clr      (clr_wr_reg & clr_bits_reg[g]),
        .rerq     (rerq_reg),
        .req      (req_w[g]),
        .pend     (pend_w[g]),
        .trig     (trig_w[g])
      );
    end
  endgenerate

  // read mux
  always @* begin
    rd_next = `EEID_RST16;
    case (AVS_ADDRESS)
      `EEID_OFF_EDGE: rd_next = edge_select_ctrl_reg & `EEID_EDGE_MASK;
      `EEID_OFF_SAMP: rd_next = {12'h000, sampling_enable_ctrl_reg};
      `EEID_OFF_DIV:  rd_next = {9'h000, sample_div_sel_reg, 4'h0};
      // (RULE9) pending flags visible
      `EEID_OFF_PEND: rd_next = {12'h000, pend_w};
      `EEID_OFF_STBY: rd_next = prescale_reg;
      // (RULE14) clear register reads zero
      `EEID_OFF_CLR:  rd_next = `EEID_RST16;
      default:        rd_next = `EEID_RST16;
    endcase
  end

  // one wait cycle per access; writes land at the accepting edge
  always @(posedge REF_CLK) begin
    if (RESET) begin
      edge_select_ctrl_reg     <= `EEID_RST16;
      sampling_enable_ctrl_reg <= {`EEID_NCH{1'b0}};
      sample_div_sel_reg       <= 3'h0;
      prescale_reg             <= `EEID_PRESCALE_DEF;
      bus_done_reg             <= 1'b0;
      clr_wr_reg               <= 1'b0;
      clr_bits_reg             <= {`EEID_NCH{1'b0}};
      rerq_reg                 <= 1'b0;
      AVS_READDATA             <= `EEID_RST16;
      AVS_WAITREQUEST          <= 1'b1;
      XIRQ_REQUEST             <= {`EEID_NCH{1'b0}};
      TIMER_TRIGGER_IN         <= {`EEID_NCH{1'b0}};
    end else begin
      clr_wr_reg       <= 1'b0;
      rerq_reg         <= 1'b0;
      XIRQ_REQUEST     <= req_w;
      TIMER_TRIGGER_IN <= trig_w;
      bus_done_reg     <= bus_req;
      AVS_WAITREQUEST  <= ~bus_req;
      if (bus_req) begin
        AVS_READDATA <= rd_next;
      end
      if (bus_done_reg && AVS_WRITE) begin
        case (AVS_ADDRESS)
          // (RULE2) only select bits stored
          `EEID_OFF_EDGE: edge_select_ctrl_reg <= AVS_WRITEDATA & `EEID_EDGE_MASK;
          // (RULE3) per channel sampling choice
          `EEID_OFF_SAMP: sampling_enable_ctrl_reg <= AVS_WRITEDATA[`EEID_NCH-1:0];
          `EEID_OFF_DIV:
            sample_div_sel_reg <= AVS_WRITEDATA[`EEID_DIV_MSB:`EEID_DIV_LSB];
          `EEID_OFF_STBY: prescale_reg <= AVS_WRITEDATA;
          `EEID_OFF_CLR: begin
            clr_wr_reg   <= 1'b1;
            clr_bits_reg <= AVS_WRITEDATA[`EEID_NCH-1:0];
            rerq_reg     <= AVS_WRITEDATA[`EEID_RERQ_BIT];
          end
          default: ;
        endcase
      end
    end
  end
endmodule

// ===== verif/eeid_pins.sv
// board model driving the four interrupt pins
`timescale 1ns/1ns
module eeid_pins (
  input  wire       clk,
  input  int        lag,
  input  wire [3:0] want,
  output reg  [3:0] pins = 4'h0
);
  int wait_cnt = 0;
  // a slow board settles lag plus one cycles after the command
  always @(posedge clk) begin
    if (pins === want || wait_cnt >= lag) begin
      pins     <= want;
      wait_cnt <= 0;
    end else begin
      wait_cnt <= wait_cnt + 1;
    end
  end
endmodule

// ===== verif/eeid_top_chk.sv
// port assertions for the interrupt detector
`timescale 1ns/1ns
`include "eeid_defs.vh"
module eeid_top_chk (
  input wire        REF_CLK,
  input wire        RESET,
  input wire [15:0] AVS_ADDRESS,
  input wire        AVS_READ,
  input wire        AVS_WRITE,
  input wire [15:0] AVS_READDATA,
  input wire        AVS_WAITREQUEST,
  input wire [3:0]  XIRQ_REQUEST
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RESET);
  sequence s_rd(a);
    AVS_READ && AVS_ADDRESS == a && !AVS_WAITREQUEST;
  endsequence
  sequence s_req;
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
  endsequence
  a_reset_quiet: assert property ($fell(RESET) |-> !XIRQ_REQUEST && AVS_WAITREQUEST)
    else $error("outputs busy after reset");
  a_ack_timely: assert property (s_req |-> ##[1:2] !AVS_WAITREQUEST)
    else $error("access not answered");
  a_ack_single: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("answer longer than one cycle");
  a_clr_zero: assert property (s_rd(`EEID_OFF_CLR) |-> AVS_READDATA == 16'h0000)
    else $error("clear register read not zero");
  a_pend_rsvd: assert property (s_rd(`EEID_OFF_PEND) |-> AVS_READDATA[15:4] == 12'h000)
    else $error("status reserved bits set");
  a_edge_rsvd: assert property (s_rd(`EEID_OFF_EDGE) |->
    (AVS_READDATA & 16'hF0F0) == 16'h0000)
    else $error("edge reserved bits set");
  a_div_rsvd: assert property (s_rd(`EEID_OFF_DIV) |->
    (AVS_READDATA & 16'hFF8F) == 16'h0000)
    else $error("divider reserved bits set");
  a_req_pulse: assert property (|XIRQ_REQUEST |=> !(XIRQ_REQUEST & $past(XIRQ_REQUEST)))
    else $error("request longer than one cycle");
endmodule
bind eeid_top eeid_top_chk chk_u (
  .REF_CLK(REF_CLK), .RESET(RESET), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
  .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .XIRQ_REQUEST(XIRQ_REQUEST)
);

// ===== verif/tb_eeid_top.sv
// self-checking bench for the interrupt detector
`timescale 1ns/1ns
`include "eeid_defs.vh"
module tb_eeid_top;
  logic        REF_CLK, RESET, AVS_READ, AVS_WRITE, STOP_MODE, AVS_WAITREQUEST;
  logic [15:0] AVS_ADDRESS, AVS_WRITEDATA, AVS_READDATA, rd, pc;
  logic [3:0]  XIRQ_PIN, XIRQ_REQUEST, TIMER_TRIGGER_IN, want;
  int          n_mismatch, compares, lag;
  eeid_pins pins_u (.clk(REF_CLK), .lag(lag), .want(want), .pins(XIRQ_PIN));
  eeid_top dut_u (
    .REF_CLK(REF_CLK), .RESET(RESET), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .XIRQ_PIN(XIRQ_PIN), .STOP_MODE(STOP_MODE),
    .XIRQ_REQUEST(XIRQ_REQUEST), .TIMER_TRIGGER_IN(TIMER_TRIGGER_IN)
  );
  task check(string nm, logic [15:0] seen, logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task complete_run;
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // request held until waitrequest is seen low at a rising edge
  task bus(logic w, logic [15:0] a, logic [15:0] d);
    int n;
    @(posedge REF_CLK);
    AVS_READ      <= !w;
    AVS_WRITE     <= w;
    AVS_ADDRESS   <= a;
    AVS_WRITEDATA <= d;
    n = 0;
    do begin
      @(posedge REF_CLK);
      n++;
    end while (AVS_WAITREQUEST !== 1'b0 && n < 40);
    rd = AVS_READDATA;
    AVS_READ  <= 1'b0;
    AVS_WRITE <= 1'b0;
    if (AVS_WAITREQUEST !== 1'b0) begin
      n_mismatch++;
      complete_run;
    end
  endtask
  task wr(logic [15:0] a, logic [15:0] d);
    bus(1'b1, a, d);
  endtask
  task rdck(string nm, logic [15:0] a, logic [15:0] exp);
    bus(1'b0, a, 16'h0000);
    check(nm, rd, exp);
  endtask
  // one nibble of pulse count per channel
  task watch(int cyc);
    pc = 16'h0000;
    repeat (cyc) begin
      @(posedge REF_CLK);
      for (int i = 0; i < 4; i++) pc[i*4+:4] += {3'h0, XIRQ_REQUEST[i]};
    end
  endtask
  task sc_regs;
    rdck("edge rst", `EEID_OFF_EDGE, 16'h0000);
    rdck("samp rst", `EEID_OFF_SAMP, 16'h0000);
    rdck("div rst", `EEID_OFF_DIV, 16'h0000);
    rdck("pend rst", `EEID_OFF_PEND, 16'h0000);
    wr(`EEID_OFF_EDGE, 16'hFFFF);
    rdck("edge bits", `EEID_OFF_EDGE, 16'h0F0F);
    wr(`EEID_OFF_SAMP, 16'hFFFF);
    rdck("samp bits", `EEID_OFF_SAMP, 16'h000F);
    wr(`EEID_OFF_DIV, 16'h00F0);
    rdck("div bits", `EEID_OFF_DIV, 16'h0070);
    wr(`EEID_OFF_CLR, 16'h000F);
    rdck("clr read", `EEID_OFF_CLR, 16'h0000);
    wr(16'hF0E0, 16'hFFFF);
    rdck("unmapped", 16'hF0E0, 16'h0000);
  endtask
  task sc_edges;
    logic [1:0] m;
    wr(`EEID_OFF_SAMP, 16'h0000);
    for (int k = 0; k < 4; k++) begin
      m = k[1:0];
      wr(`EEID_OFF_EDGE, {4'h0, {4{m[1]}}, 4'h0, {4{m[0]}}});
      want <= 4'hF;
      watch(12);
      check("rise", pc, m[1] ? 16'h1111 : 16'h0000);
      check("trigger", {12'h000, TIMER_TRIGGER_IN}, 16'h000F);
      rdck("pend", `EEID_OFF_PEND, m[1] ? 16'h000F : 16'h0000);
      wr(`EEID_OFF_CLR, 16'h000F);
      want <= 4'h0;
      watch(12);
      check("fall", pc, m[0] ? 16'h1111 : 16'h0000);
      wr(`EEID_OFF_CLR, 16'h000F);
    end
  endtask
  task sc_block;
    lag <= 3;
    wr(`EEID_OFF_EDGE, 16'h0F0F);
    want <= 4'hF;
    watch(16);
    check("first", pc, 16'h1111);
    want <= 4'h0;
    watch(16);
    check("blocked", pc, 16'h0000);
    wr(`EEID_OFF_CLR, 16'h0001);
    rdck("clr one", `EEID_OFF_PEND, 16'h000E);
    wr(`EEID_OFF_CLR, 16'h8000);
    watch(8);
    check("rerequest", pc, 16'h1110);
    wr(`EEID_OFF_CLR, 16'h0000);
    watch(8);
    check("zero write", pc, 16'h0000);
    rdck("kept", `EEID_OFF_PEND, 16'h000E);
    wr(`EEID_OFF_CLR, 16'h000F);
    lag <= 0;
  endtask
  // sample tick every cycle with prescale zero and divider 111, every 64 cycles with 110
  task sc_sampled;
    wr(`EEID_OFF_STBY, 16'h0000);
    wr(`EEID_OFF_SAMP, 16'h000F);
    wr(`EEID_OFF_EDGE, 16'h0F00);
    wr(`EEID_OFF_DIV, 16'h0070);
    want <= 4'h1;
    watch(20);
    check("div seven", pc, 16'h0001);
    want <= 4'h3;
    @(posedge REF_CLK);
    want <= 4'h1;
    watch(20);
    check("glitch", pc, 16'h0000);
    STOP_MODE <= 1'b1;
    watch(4);
    want <= 4'h5;
    watch(20);
    check("standby", pc, 16'h0000);
    STOP_MODE <= 1'b0;
    wr(`EEID_OFF_DIV, 16'h0060);
    want <= 4'hD;
    watch(150);
    check("div early", pc, 16'h0000);
    watch(150);
    check("div late", pc, 16'h1000);
    check("samp trigger", {12'h000, TIMER_TRIGGER_IN}, 16'h000D);
  endtask
  initial begin
    REF_CLK = 1'b0;
    forever #2 REF_CLK = ~REF_CLK;
  end
  initial begin
    RESET         = 1'b1;
    AVS_READ      = 1'b0;
    AVS_WRITE     = 1'b0;
    AVS_ADDRESS   = 16'h0000;
    AVS_WRITEDATA = 16'h0000;
    STOP_MODE     = 1'b0;
    want          = 4'h0;
    lag           = 0;
    repeat (6) @(posedge REF_CLK);
    RESET <= 1'b0;
    sc_regs;
    sc_edges;
    sc_block;
    sc_sampled;
    complete_run;
  end
endmodule
